/* verilog/xcvr_consts.svh */
// Constants for the registered bus transceiver
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH
`define XCVR_DATA_W 18
`define XCVR_STORE_RESET 18'h00000
`define XCVR_BUF_DEPTH 2
`endif

/* verilog/xcvr_pkg.sv */
// Types shared by the registered bus transceiver files
`include "xcvr_consts.svh"
package xcvr_pkg;
    typedef logic [`XCVR_DATA_W-1:0] word_t;
    typedef enum logic [1:0] {
        MODE_HOLD        = 2'b00,
        MODE_TRANSPARENT = 2'b01,
        MODE_LATCH_EDGE  = 2'b10,
        MODE_CLOCK_EDGE  = 2'b11
    } store_mode_t;
endpackage

/* verilog/dir_path.sv */
// One direction: storage stage, two-entry buffer and output driver
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_consts.svh"
module dir_path (
    input  wire logic           clock,
    input  wire logic           rst_n,
    input  wire logic           clk_en,
    input  wire xcvr_pkg::word_t in_data,
    input  wire logic           latch_en,
    input  wire logic           latch_en_prev,
    input  wire logic           cap_clk,
    input  wire logic           cap_clk_prev,
    input  wire logic           drive_en,
    input  wire logic           out_ready,
    output logic                in_ready,
    output xcvr_pkg::word_t     store_q,
    output logic                out_valid,
    output xcvr_pkg::word_t     out_data,
    output logic                out_oe
);
    // ****************************************
    // Storage stage mode select
    // ****************************************
    xcvr_pkg::store_mode_t mode;
    xcvr_pkg::word_t       store_ff, nxt_store;
    logic                  load;

    always_comb begin
        if (latch_en)
            mode = xcvr_pkg::MODE_TRANSPARENT;
        else if (latch_en_prev)
            mode = xcvr_pkg::MODE_LATCH_EDGE;
        else if (cap_clk_prev && !cap_clk)
            mode = xcvr_pkg::MODE_CLOCK_EDGE;
        else
            mode = xcvr_pkg::MODE_HOLD;
    end

    // storage ignores output enables
    // Storage keeps working whether or not outputs drive
    always_comb begin
        load = 1'b0;
        unique case (mode)
            xcvr_pkg::MODE_TRANSPARENT: load = 1'b1;
            // keep pre-edge word
            // Store already holds it; loading now would take post-edge data
            xcvr_pkg::MODE_LATCH_EDGE:  load = 1'b0;
            xcvr_pkg::MODE_CLOCK_EDGE:  load = 1'b1;
            xcvr_pkg::MODE_HOLD:        load = 1'b0;
        endcase
        // Store only while buffer can take the word
        nxt_store = (load && in_ready) ? in_data : store_ff;
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            store_ff <= `XCVR_STORE_RESET;
        else if (clk_en)
            store_ff <= nxt_store;
    end

    assign store_q = store_ff;

    // ****************************************
    // Two-entry buffer toward the output
    // ****************************************
    xcvr_pkg::word_t mem_ff [`XCVR_BUF_DEPTH];
    xcvr_pkg::word_t nxt_mem [`XCVR_BUF_DEPTH];
    logic [1:0] cnt_ff, nxt_cnt;
    logic       wr, rd;
    xcvr_pkg::word_t od_ff, nxt_od;
    logic       ov_ff, nxt_ov, oe_ff, nxt_oe;

    assign in_ready = (cnt_ff != 2'd2);

    always_comb begin
        // Push a word when storage actually changed, or on any load while the buffer is empty
        wr = load && in_ready && (in_data != store_ff || cnt_ff == 2'd0);
        rd = (cnt_ff != 2'd0) && (!ov_ff || out_ready);
        nxt_mem = mem_ff;
        nxt_cnt = cnt_ff;
        nxt_od  = od_ff;
        nxt_ov  = ov_ff && !out_ready;
        if (rd) begin
            nxt_od     = mem_ff[0];
            nxt_ov     = 1'b1;
            nxt_mem[0] = mem_ff[1];
        end
        if (wr)
            nxt_mem[(rd ? cnt_ff - 2'd1 : cnt_ff) == 2'd0 ? 0 : 1] = in_data;
        nxt_cnt = cnt_ff + {1'b0, wr} - {1'b0, rd};
        nxt_oe  = drive_en;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_ff[0] <= `XCVR_STORE_RESET;
            mem_ff[1] <= `XCVR_STORE_RESET;
            cnt_ff    <= 2'd0;
            od_ff     <= `XCVR_STORE_RESET;
            ov_ff     <= 1'b0;
            oe_ff     <= 1'b0;
        end else if (clk_en) begin
            mem_ff <= nxt_mem;
            cnt_ff <= nxt_cnt;
            od_ff  <= nxt_od;
            ov_ff  <= nxt_ov;
            oe_ff  <= nxt_oe;
        end
    end

    assign out_data  = od_ff;
    assign out_valid = ov_ff;
    assign out_oe    = oe_ff;
endmodule
`default_nettype wire

/* verilog/bus_xcvr.sv */
// Top of the 18-bit registered bus transceiver, both directions
// Overview of operation
// - Eighteen bits pass unchanged each way, each side with its own output enable.
// - With the A-to-B latch enable high, A data flows through storage to B.
// - With latch enable low and the capture clock steady, stored A-to-B data holds.
// - With latch enable low, A data is stored on each falling capture clock edge while the buffer is not full, except in the cycle latch enable falls.
// - A-to-B output enable high drives B from storage, low releases B.
// - B-to-A has the same modes with its own controls, driving the A side.
// - The B-to-A output enable is active low.
// - A falling latch enable keeps the data seen just before the edge.
// - Storage keeps updating while outputs are released.
// - Each direction has 18 storage bits acting as latch or flip-flop.
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_consts.svh"
module bus_xcvr (
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            clk_en,
    input  wire xcvr_pkg::word_t a_side_data_in,
    output xcvr_pkg::word_t      a_side_data_out,
    output logic                 a_side_data_oe,
    input  wire xcvr_pkg::word_t b_side_data_in,
    output xcvr_pkg::word_t      b_side_data_out,
    output logic                 b_side_data_oe,
    input  wire logic            a_to_b_output_enable,
    input  wire logic            b_to_a_output_enable_n,
    input  wire logic            a_to_b_latch_enable,
    input  wire logic            b_to_a_latch_enable,
    input  wire logic            a_to_b_capture_clock,
    input  wire logic            b_to_a_capture_clock,
    input  wire logic            b_side_ready,
    input  wire logic            a_side_ready,
    output logic                 b_side_valid,
    output logic                 a_side_valid
);
    // ****************************************
    // Pin synchronisers, two stages each
    // ****************************************
    localparam int NCTL = 6;
    logic [NCTL-1:0] ctl_raw, ctl_s1_ff, ctl_s2_ff, ctl_prev_ff;
    logic [NCTL-1:0] nxt_s1, nxt_s2, nxt_prev;
    xcvr_pkg::word_t a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;

    assign ctl_raw = {a_to_b_output_enable, b_to_a_output_enable_n,
                      a_to_b_latch_enable, b_to_a_latch_enable,
                      a_to_b_capture_clock, b_to_a_capture_clock};

    // Previous level feeds edge detect, never the first stage
    always_comb begin
        nxt_s1   = ctl_raw;
        nxt_s2   = ctl_s1_ff;
        nxt_prev = ctl_s2_ff;
    end

    always_ff @(posedge clock) begin
        // idle levels at reset
        // Active-low enable resets high, or A side drives after reset
        if (!rst_n) begin
            ctl_s1_ff   <= 6'h10;
            ctl_s2_ff   <= 6'h10;
            ctl_prev_ff <= 6'h10;
            a_s1_ff     <= `XCVR_STORE_RESET;
            a_s2_ff     <= `XCVR_STORE_RESET;
            b_s1_ff     <= `XCVR_STORE_RESET;
            b_s2_ff     <= `XCVR_STORE_RESET;
        end else if (clk_en) begin
            ctl_s1_ff   <= nxt_s1;
            ctl_s2_ff   <= nxt_s2;
            ctl_prev_ff <= nxt_prev;
            // Data delayed like controls, so pre-edge data is kept
            a_s1_ff     <= a_side_data_in;
            a_s2_ff     <= a_s1_ff;
            b_s1_ff     <= b_side_data_in;
            b_s2_ff     <= b_s1_ff;
        end
    end

    // ****************************************
    // Direction paths
    // ****************************************
    xcvr_pkg::word_t ab_q, ba_q;
    logic ba_drive;
    assign ba_drive = !ctl_s2_ff[4];

    dir_path u_ab (
        .clock         (clock),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .in_data       (a_s2_ff),
        .latch_en      (ctl_s2_ff[3]),
        .latch_en_prev (ctl_prev_ff[3]),
        .cap_clk       (ctl_s2_ff[1]),
        .cap_clk_prev  (ctl_prev_ff[1]),
        .drive_en      (ctl_s2_ff[5]),
        .out_ready     (b_side_ready),
        .in_ready      (),
        .store_q       (ab_q),
        .out_valid     (b_side_valid),
        .out_data      (b_side_data_out),
        .out_oe        (b_side_data_oe)
    );

    dir_path u_ba (
        .clock         (clock),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .in_data       (b_s2_ff),
        .latch_en      (ctl_s2_ff[2]),
        .latch_en_prev (ctl_prev_ff[2]),
        .cap_clk       (ctl_s2_ff[0]),
        .cap_clk_prev  (ctl_prev_ff[0]),
        .drive_en      (ba_drive),
        .out_ready     (a_side_ready),
        .in_ready      (),
        .store_q       (ba_q),
        .out_valid     (a_side_valid),
        .out_data      (a_side_data_out),
        .out_oe        (a_side_data_oe)
    );
endmodule
`default_nettype wire

/* verif/bus_xcvr_props.sv */
// Assertion checker for the bus transceiver top
`timescale 1ns/1ns
`default_nettype none
module bus_xcvr_props (
    input wire logic            clock,
    input wire logic            rst_n,
    input wire xcvr_pkg::word_t a_side_data_in,
    input wire xcvr_pkg::word_t a_side_data_out,
    input wire logic            a_side_data_oe,
    input wire xcvr_pkg::word_t b_side_data_out,
    input wire logic            b_side_data_oe,
    input wire logic            a_to_b_output_enable,
    input wire logic            b_to_a_output_enable_n,
    input wire logic            a_to_b_latch_enable,
    input wire logic            b_to_a_latch_enable,
    input wire logic            a_to_b_capture_clock,
    input wire logic            b_to_a_capture_clock,
    input wire logic            b_side_ready,
    input wire logic            a_side_ready,
    input wire logic            b_side_valid,
    input wire logic            a_side_valid
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rst_off;
        $rose(rst_n) |-> !(a_side_data_oe || b_side_data_oe || a_side_valid || b_side_valid);
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("active after reset");
    property p_oe_ab; b_side_data_oe == $past(a_to_b_output_enable, 3); endproperty
    a_oe_ab: assert property (p_oe_ab) else $error("b side enable wrong");
    property p_oe_ba; a_side_data_oe == !$past(b_to_a_output_enable_n, 3); endproperty
    a_oe_ba: assert property (p_oe_ba) else $error("a side enable wrong");
    // Stalled words must stand, or a receiver stall loses data
    property p_stand_b;
        b_side_valid && !b_side_ready |=> b_side_valid && $stable(b_side_data_out);
    endproperty
    a_stand_b: assert property (p_stand_b) else $error("b word dropped");
    property p_stand_a;
        a_side_valid && !a_side_ready |=> a_side_valid && $stable(a_side_data_out);
    endproperty
    a_stand_a: assert property (p_stand_a) else $error("a word dropped");
    property p_hold_ab;
        (!a_to_b_latch_enable && $stable(a_to_b_capture_clock) && b_side_ready)[*8]
            |-> $stable(b_side_data_out);
    endproperty
    a_hold_ab: assert property (p_hold_ab) else $error("b word moved");
    property p_hold_ba;
        (!b_to_a_latch_enable && $stable(b_to_a_capture_clock) && a_side_ready)[*8]
            |-> $stable(a_side_data_out);
    endproperty
    a_hold_ba: assert property (p_hold_ba) else $error("a word moved");
    property p_pass_ab;
        (a_to_b_latch_enable && b_side_ready && $stable(a_side_data_in))[*8]
            |-> b_side_data_out == a_side_data_in;
    endproperty
    a_pass_ab: assert property (p_pass_ab) else $error("no flow through");
endmodule
bind bus_xcvr bus_xcvr_props u_props (.*);
`default_nettype wire

/* verif/bus_sink.sv */
// Far-side receiver model; the bench may stall it
`timescale 1ns/1ns
`default_nettype none
module bus_sink (
    input  wire logic            clock,
    input  wire logic            stall,
    input  wire logic            valid,
    input  wire xcvr_pkg::word_t data,
    output logic                 ready,
    output xcvr_pkg::word_t      last_ff
);
    // Registered ready, so a stall lands one cycle late
    always_ff @(posedge clock) begin
        ready <= !stall;
        if (valid && ready) begin
            last_ff <= data;
        end
    end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the bus transceiver
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock, rst_n, clk_en, a_side_data_oe, b_side_data_oe, stall_a, stall_b;
    logic a_to_b_output_enable, b_to_a_output_enable_n, a_to_b_latch_enable;
    logic b_to_a_latch_enable, a_to_b_capture_clock, b_to_a_capture_clock;
    logic b_side_ready, a_side_ready, b_side_valid, a_side_valid;
    xcvr_pkg::word_t a_side_data_in, a_side_data_out, b_side_data_in, b_side_data_out;
    xcvr_pkg::word_t got_a, got_b;
    int bad_count, compares;
    bus_xcvr DUT (.*);
    bus_sink sink_b (.clock(clock), .stall(stall_b), .valid(b_side_valid),
        .data(b_side_data_out), .ready(b_side_ready), .last_ff(got_b));
    bus_sink sink_a (.clock(clock), .stall(stall_a), .valid(a_side_valid),
        .data(a_side_data_out), .ready(a_side_ready), .last_ff(got_a));
    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input xcvr_pkg::word_t seen, input xcvr_pkg::word_t exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Flow through, latch edge, rising and falling capture edges
    task automatic t_ab();
        a_to_b_output_enable = 1'b1;
        a_to_b_latch_enable = 1'b1;
        a_side_data_in = 18'h2a5c3;
        tick(8);
        chk(got_b, 18'h2a5c3);
        chk(18'(b_side_data_oe), 18'h00001);
        a_to_b_latch_enable = 1'b0;
        a_side_data_in = 18'h15a3c;
        tick(8);
        chk(b_side_data_out, 18'h2a5c3);
        a_to_b_capture_clock = 1'b1;
        tick(8);
        chk(b_side_data_out, 18'h2a5c3);
        a_to_b_capture_clock = 1'b0;
        tick(8);
        chk(got_b, 18'h15a3c);
        a_to_b_output_enable = 1'b0;
        tick(4);
        chk(18'(b_side_data_oe), 18'h00000);
        $display("test a_to_b done");
    endtask
    // Loading while released, then active-low enable
    task automatic t_ba();
        b_to_a_latch_enable = 1'b1;
        b_side_data_in = 18'h3c0f1;
        tick(8);
        chk(a_side_data_out, 18'h3c0f1);
        chk(18'(a_side_data_oe), 18'h00000);
        b_to_a_output_enable_n = 1'b0;
        b_to_a_latch_enable = 1'b0;
        b_side_data_in = 18'h0ff00;
        b_to_a_capture_clock = 1'b1;
        tick(4);
        chk(18'(a_side_data_oe), 18'h00001);
        b_to_a_capture_clock = 1'b0;
        tick(8);
        chk(got_a, 18'h0ff00);
        b_to_a_output_enable_n = 1'b1;
        $display("test b_to_a done");
    endtask
    // Receiver stall fills the buffer; nothing may be lost
    task automatic t_stall();
        stall_b = 1'b1;
        a_to_b_latch_enable = 1'b1;
        a_side_data_in = 18'h00aa5;
        tick(8);
        chk(18'(b_side_valid), 18'h00001);
        a_side_data_in = 18'h1b00c;
        tick(3);
        a_side_data_in = 18'h2d00e;
        tick(8);
        chk(b_side_data_out, 18'h00aa5);
        stall_b = 1'b0;
        tick(12);
        chk(got_b, 18'h2d00e);
        $display("test stall done");
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Reset for 16 cycles, then the scenarios
    initial begin
        bad_count = 0;
        compares = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        b_to_a_output_enable_n = 1'b1;
        {a_to_b_output_enable, a_to_b_latch_enable, b_to_a_latch_enable} = 3'h0;
        {a_to_b_capture_clock, b_to_a_capture_clock, stall_a, stall_b} = 4'h0;
        a_side_data_in = 18'h00000;
        b_side_data_in = 18'h00000;
        tick(16);
        rst_n = 1'b1;
        tick(1);
        chk(18'({a_side_data_oe, b_side_data_oe, a_side_valid, b_side_valid}), 18'h0);
        t_ab();
        t_ba();
        t_stall();
        final_report();
    end
endmodule
`default_nettype wire
